// ==== shared/fcr_pkg.sv ====
package fcr_pkg;

  localparam int CODE_W = 10;

  // Fault codes; all but CODE_RTC_BAD and CODE_CELL_LOW are reported in the status value.
  localparam logic [9:0] CODE_NONE     = 10'h000;
  localparam logic [9:0] CODE_IO_ACC   = 10'h021;
  localparam logic [9:0] CODE_SPEC_ACC = 10'h022;
  localparam logic [9:0] CODE_CPU_HALT = 10'h027;
  localparam logic [9:0] CODE_SCAN_WDT = 10'h028;
  localparam logic [9:0] CODE_OPER_RUN = 10'h029;
  localparam logic [9:0] CODE_STACK    = 10'h02a;
  localparam logic [9:0] CODE_BASE_DUP = 10'h02b;
  localparam logic [9:0] CODE_TMR_IDX  = 10'h02c;
  localparam logic [9:0] CODE_EXT_DEV  = 10'h032;
  localparam logic [9:0] CODE_TASK_OVF = 10'h037;
  localparam logic [9:0] CODE_ESTOP    = 10'h03c;
  localparam logic [9:0] CODE_OPER_ERR = 10'h03d;
  localparam logic [9:0] CODE_BACKUP   = 10'h1f4;
  localparam logic [9:0] CODE_RTC_BAD  = 10'h1f5;
  localparam logic [9:0] CODE_CELL_LOW = 10'h1f6;

  // Nonzero codes at or below this limit enter the history.
  localparam logic [9:0] HIST_LIMIT    = 10'h016;
  localparam int         HIST_DEPTH    = 8;

  // Bit positions of the fault vector, also its priority order (low wins).
  localparam int F_HALT  = 0;
  localparam int F_ESTOP = 1;
  localparam int F_WDT   = 2;
  localparam int F_STACK = 3;
  localparam int F_OPRUN = 4;
  localparam int F_BASE  = 5;
  localparam int F_BKUP  = 6;
  localparam int F_IO    = 7;
  localparam int F_SPEC  = 8;
  localparam int F_TMR   = 9;
  localparam int F_EXT   = 10;
  localparam int F_TASK  = 11;
  localparam int F_OPER  = 12;
  localparam int NFAULT  = 13;

  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAULT = 2'b10,
    ST_LOCK  = 2'b11
  } fcr_state_t;

endpackage : fcr_pkg

// ==== rtl/fcr_history.sv ====
`timescale 1ns/1ps
// Small ring of recorded error codes readable by an external tool.
module fcr_history #(
  parameter int DEPTH = fcr_pkg::HIST_DEPTH
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Write side
  input  wire logic                      wr_i,
  input  wire logic [fcr_pkg::CODE_W-1:0] code_i,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0]  rd_idx_i,
  output logic      [fcr_pkg::CODE_W-1:0] rd_code_o,
  output logic      [$clog2(DEPTH):0]    count_o
);

  logic [fcr_pkg::CODE_W-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0]   wp_q;
  logic [$clog2(DEPTH):0]     cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      cnt_q <= '0;
    end else if (wr_i) begin
      wp_q <= wp_q + 1'b1;
      if (cnt_q != DEPTH[$clog2(DEPTH):0]) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[wp_q] <= code_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_code_o <= '0;
    end else begin
      rd_code_o <= mem_q[rd_idx_i];
    end
  end

  assign count_o = cnt_q;

endmodule : fcr_history

// ==== rtl/fcr_top.sv ====
`timescale 1ns/1ps
module fcr_top #(
  parameter int STEP_W = 16,
  parameter int HDEPTH = fcr_pkg::HIST_DEPTH
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Mode control
  input  wire logic                        run_req_i,
  input  wire logic                        restart_i,
  input  wire logic                        scan_end_i,
  input  wire logic                        prog_active_i,
  input  wire logic                        prog_reload_i,
  // Reaction selection, one bit per selectable fault (1 = continue)
  input  wire logic                        cont_io_i,
  input  wire logic                        cont_spec_i,
  input  wire logic                        cont_tmr_i,
  input  wire logic                        cont_ext_i,
  input  wire logic                        cont_task_i,
  input  wire logic                        cont_oper_i,
  // Fault conditions
  input  wire logic                        io_fail_i,
  input  wire logic                        spec_fail_i,
  input  wire logic                        cpu_halt_i,
  input  wire logic                        scan_wdt_i,
  input  wire logic                        oper_run_i,
  input  wire logic                        stack_bad_i,
  input  wire logic                        base_dup_i,
  input  wire logic                        tmr_idx_i,
  input  wire logic                        ext_fault_i,
  input  wire logic                        task_ovf_i,
  input  wire logic                        estop_i,
  input  wire logic                        oper_err_i,
  input  wire logic [STEP_W-1:0]           oper_step_i,
  input  wire logic                        backup_lost_i,
  input  wire logic                        rtc_bad_i,
  input  wire logic                        cell_low_i,
  // History access and other code source
  input  wire logic                        hist_wr_i,
  input  wire logic [fcr_pkg::CODE_W-1:0]  hist_code_i,
  input  wire logic [$clog2(HDEPTH)-1:0]   hist_idx_i,
  output logic      [fcr_pkg::CODE_W-1:0]  hist_code_o,
  output logic      [$clog2(HDEPTH):0]     hist_count_o,
  // Status and indicators
  output logic      [fcr_pkg::CODE_W-1:0]  err_code_o,
  output logic      [STEP_W-1:0]           err_step_o,
  output logic                             running_o,
  output logic                             run_led_o,
  output logic                             err_led_o,
  output logic                             cont_fault_led_o,
  output logic                             clock_warning_indicator_o,
  output logic                             cell_low_indicator_o
);

  fcr_pkg::fcr_state_t state_q;
  logic [fcr_pkg::NFAULT-1:0] flt;
  logic [fcr_pkg::NFAULT-1:0] cont_sel;
  logic [fcr_pkg::NFAULT-1:0] run_lit;
  logic                       any_flt;
  logic                       any_stop;
  logic                       rst_seen_q;
  logic [fcr_pkg::CODE_W-1:0] new_code;
  logic                       new_run_lit;
  logic                       hist_wr;
  logic [fcr_pkg::CODE_W-1:0] hist_wcode;

  function automatic logic [fcr_pkg::CODE_W-1:0] code_of(input int idx);
    unique case (idx)
      fcr_pkg::F_HALT:  code_of = fcr_pkg::CODE_CPU_HALT;
      fcr_pkg::F_ESTOP: code_of = fcr_pkg::CODE_ESTOP;
      fcr_pkg::F_WDT:   code_of = fcr_pkg::CODE_SCAN_WDT;
      fcr_pkg::F_STACK: code_of = fcr_pkg::CODE_STACK;
      fcr_pkg::F_OPRUN: code_of = fcr_pkg::CODE_OPER_RUN;
      fcr_pkg::F_BASE:  code_of = fcr_pkg::CODE_BASE_DUP;
      fcr_pkg::F_BKUP:  code_of = fcr_pkg::CODE_BACKUP;
      fcr_pkg::F_IO:    code_of = fcr_pkg::CODE_IO_ACC;
      fcr_pkg::F_SPEC:  code_of = fcr_pkg::CODE_SPEC_ACC;
      fcr_pkg::F_TMR:   code_of = fcr_pkg::CODE_TMR_IDX;
      fcr_pkg::F_EXT:   code_of = fcr_pkg::CODE_EXT_DEV;
      fcr_pkg::F_TASK:  code_of = fcr_pkg::CODE_TASK_OVF;
      default:          code_of = fcr_pkg::CODE_OPER_ERR;
    endcase
  endfunction : code_of

  wire in_run = (state_q == fcr_pkg::ST_RUN);
  wire to_run = (state_q == fcr_pkg::ST_STOP) && run_req_i;

  // Each fault is qualified by its own diagnostic point.
  always_comb begin
    flt = '0;
    flt[fcr_pkg::F_HALT]  = cpu_halt_i && state_q != fcr_pkg::ST_LOCK;
    flt[fcr_pkg::F_ESTOP] = estop_i && in_run && prog_active_i;
    flt[fcr_pkg::F_WDT]   = scan_wdt_i && in_run;
    flt[fcr_pkg::F_STACK] = stack_bad_i && in_run && prog_active_i;
    flt[fcr_pkg::F_OPRUN] = oper_run_i && in_run && prog_active_i;
    flt[fcr_pkg::F_BASE]  = base_dup_i && (to_run || !rst_seen_q);
    flt[fcr_pkg::F_BKUP]  = backup_lost_i && !rst_seen_q;
    flt[fcr_pkg::F_IO]    = io_fail_i && in_run && scan_end_i;
    flt[fcr_pkg::F_SPEC]  = spec_fail_i && in_run && scan_end_i;
    flt[fcr_pkg::F_TMR]   = tmr_idx_i && in_run && scan_end_i;
    flt[fcr_pkg::F_EXT]   = ext_fault_i && in_run && scan_end_i;
    flt[fcr_pkg::F_TASK]  = task_ovf_i && in_run && prog_active_i;
    flt[fcr_pkg::F_OPER]  = oper_err_i && in_run && prog_active_i;
  end

  always_comb begin
    cont_sel = '0;
    cont_sel[fcr_pkg::F_IO]   = cont_io_i;
    cont_sel[fcr_pkg::F_SPEC] = cont_spec_i;
    cont_sel[fcr_pkg::F_TMR]  = cont_tmr_i;
    cont_sel[fcr_pkg::F_EXT]  = cont_ext_i;
    cont_sel[fcr_pkg::F_TASK] = cont_task_i;
    cont_sel[fcr_pkg::F_OPER] = cont_oper_i;
    run_lit = '0;
    run_lit[fcr_pkg::F_HALT]  = 1'b1;
    run_lit[fcr_pkg::F_ESTOP] = 1'b1;
    run_lit[fcr_pkg::F_WDT]   = 1'b1;
    run_lit[fcr_pkg::F_STACK] = 1'b1;
    run_lit[fcr_pkg::F_OPRUN] = 1'b1;
    run_lit[fcr_pkg::F_TMR]   = 1'b1;
  end

  assign any_flt  = |flt;
  assign any_stop = |(flt & ~cont_sel);

  // Lowest index of the active faults decides the reported code.
  always_comb begin
    new_code    = fcr_pkg::CODE_NONE;
    new_run_lit = 1'b0;
    for (int i = fcr_pkg::NFAULT - 1; i >= 0; i--) begin
      if (flt[i]) begin
        new_code    = code_of(i);
        new_run_lit = run_lit[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= fcr_pkg::ST_STOP;
    end else begin
      unique case (state_q)
        fcr_pkg::ST_STOP: begin
          if (flt[fcr_pkg::F_HALT] || flt[fcr_pkg::F_BASE] || flt[fcr_pkg::F_BKUP]) begin
            state_q <= fcr_pkg::ST_FAULT;
          end else if (run_req_i) begin
            state_q <= fcr_pkg::ST_RUN;
          end
        end
        fcr_pkg::ST_RUN: begin
          if (flt[fcr_pkg::F_ESTOP]) begin
            state_q <= fcr_pkg::ST_LOCK;
          end else if (any_stop) begin
            state_q <= fcr_pkg::ST_FAULT;
          end else if (!run_req_i) begin
            state_q <= fcr_pkg::ST_STOP;
          end
        end
        fcr_pkg::ST_FAULT: begin
          if (restart_i && !any_flt &&
              !(err_code_o == fcr_pkg::CODE_OPER_RUN && !prog_reload_i)) begin
            state_q <= fcr_pkg::ST_STOP;
          end
        end
        fcr_pkg::ST_LOCK: begin
          state_q <= fcr_pkg::ST_LOCK;
        end
      endcase
    end
  end

  // Latest code and indicators; a new fault wins over a same-cycle restart.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_code_o       <= fcr_pkg::CODE_NONE;
      run_led_o        <= 1'b0;
      err_led_o        <= 1'b0;
      cont_fault_led_o <= 1'b0;
    end else if (any_flt) begin
      err_code_o       <= new_code;
      run_led_o        <= new_run_lit;
      err_led_o        <= 1'b1;
      cont_fault_led_o <= !any_stop || cont_fault_led_o;
    end else if (restart_i && state_q != fcr_pkg::ST_LOCK &&
                 !(state_q == fcr_pkg::ST_FAULT && err_code_o == fcr_pkg::CODE_OPER_RUN
                   && !prog_reload_i)) begin
      err_code_o       <= fcr_pkg::CODE_NONE;
      run_led_o        <= 1'b0;
      err_led_o        <= 1'b0;
      cont_fault_led_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_step_o <= '0;
    end else if (flt[fcr_pkg::F_OPER] && cont_oper_i) begin
      err_step_o <= oper_step_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_o                 <= 1'b0;
      clock_warning_indicator_o <= 1'b0;
      cell_low_indicator_o      <= 1'b0;
    end else begin
      running_o                 <= (state_q == fcr_pkg::ST_RUN);
      clock_warning_indicator_o <= rtc_bad_i;
      cell_low_indicator_o      <= cell_low_i;
    end
  end

  assign hist_wr    = hist_wr_i && hist_code_i != fcr_pkg::CODE_NONE &&
                      hist_code_i <= fcr_pkg::HIST_LIMIT;
  assign hist_wcode = hist_code_i;

  fcr_history #(
    .DEPTH (HDEPTH)
  ) u_hist (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (hist_wr),
    .code_i    (hist_wcode),
    .rd_idx_i  (hist_idx_i),
    .rd_code_o (hist_code_o),
    .count_o   (hist_count_o)
  );

  // Checks.
  sequence io_seen_s;
    io_fail_i && in_run && scan_end_i;
  endsequence

  io_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    io_seen_s and !(|flt[fcr_pkg::F_IO-1:0]) |=> err_code_o == fcr_pkg::CODE_IO_ACC && err_led_o)
    else $error("io fault code missing");
  spec_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flt == (1 << fcr_pkg::F_SPEC) |=> err_code_o == fcr_pkg::CODE_SPEC_ACC)
    else $error("special fault code missing");
  halt_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cpu_halt_i && state_q != fcr_pkg::ST_LOCK |=> state_q == fcr_pkg::ST_FAULT
    && run_led_o && err_led_o && err_code_o == fcr_pkg::CODE_CPU_HALT)
    else $error("halt not handled");
  wdt_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flt == (1 << fcr_pkg::F_WDT) |=> state_q == fcr_pkg::ST_FAULT && run_led_o)
    else $error("watchdog not handled");
  estop_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flt[fcr_pkg::F_ESTOP] |=> (state_q == fcr_pkg::ST_LOCK) [*4])
    else $error("emergency stop left");
  io_scan_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_run && !scan_end_i && !prog_active_i && !restart_i && !cpu_halt_i && !scan_wdt_i
    |=> $stable(err_code_o))
    else $error("code changed off scan end");
  cont_led_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    any_flt && !any_stop && run_req_i |=> cont_fault_led_o && state_q == $past(state_q))
    else $error("continue fault not lit");
  step_rec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flt[fcr_pkg::F_OPER] && cont_oper_i |=> err_step_o == $past(oper_step_i))
    else $error("failing step not recorded");
  cell_led_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cell_low_i |=> cell_low_indicator_o)
    else $error("battery lamp off");
  rtc_led_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rtc_bad_i && !any_flt && in_run && run_req_i |=> clock_warning_indicator_o
    && state_q == fcr_pkg::ST_RUN)
    else $error("clock lamp off");

endmodule : fcr_top

// ==== tb/fcr_base_model.sv ====
`timescale 1ns/1ps
// Base side: gives a scan end pulse every SCAN cycles and reports module access faults.
module fcr_base_model #(
  parameter int SCAN = 4
) (
  // Clock
  input  wire logic clk_i,
  // Control from the bench
  input  wire logic scan_en_i,
  input  wire logic brk_io_i,
  input  wire logic brk_spec_i,
  // Towards the reporter
  output logic      scan_end_o,
  output logic      io_fail_o,
  output logic      spec_fail_o
);
  int cnt_q;

  initial begin
    cnt_q       = 0;
    scan_end_o  = 1'b0;
    io_fail_o   = 1'b0;
    spec_fail_o = 1'b0;
  end

  // Sampling on the rising edge keeps clear of the bench, which drives on the falling edge.
  always @(posedge clk_i) begin
    cnt_q       <= (cnt_q == SCAN - 1) ? 0 : cnt_q + 1;
    scan_end_o  <= scan_en_i && (cnt_q == SCAN - 1);
    io_fail_o   <= brk_io_i;
    spec_fail_o <= brk_spec_i;
  end
endmodule : fcr_base_model

// ==== tb/fcr_top_tb.sv ====
`timescale 1ns/1ps
`define EXPECT(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module fcr_top_tb;
  typedef struct packed {
    logic [14:0] f;
    logic [5:0]  c;
    logic [9:0]  code;
    logic        run;
    logic        rled;
    logic        cled;
  } fcr_row_t;

  logic        clk_i;
  logic        rst_n_i;
  logic        run_req;
  logic        restart;
  logic        prog_act;
  logic        reload;
  logic        scan_en;
  logic [14:0] flt;
  logic [5:0]  cont_sel;
  logic        hist_wr;
  logic [9:0]  hist_code;
  logic [2:0]  hist_idx;
  logic        scan_end;
  logic        io_fail;
  logic        spec_fail;
  logic [9:0]  hist_code_o;
  logic [3:0]  hist_count_o;
  logic [9:0]  err_code_o;
  logic [15:0] err_step_o;
  logic        running_o;
  logic        run_led_o;
  logic        err_led_o;
  logic        cont_fault_led_o;
  logic        clock_warning_indicator_o;
  logic        cell_low_indicator_o;
  int          errors;
  int          tests_run;

  fcr_row_t rows [17] = '{
    '{15'h0001, 6'h00, fcr_pkg::CODE_IO_ACC,   1'b0, 1'b0, 1'b0},
    '{15'h0001, 6'h01, fcr_pkg::CODE_IO_ACC,   1'b1, 1'b0, 1'b1},
    '{15'h0002, 6'h00, fcr_pkg::CODE_SPEC_ACC, 1'b0, 1'b0, 1'b0},
    '{15'h0002, 6'h02, fcr_pkg::CODE_SPEC_ACC, 1'b1, 1'b0, 1'b1},
    '{15'h0004, 6'h00, fcr_pkg::CODE_CPU_HALT, 1'b0, 1'b1, 1'b0},
    '{15'h0008, 6'h00, fcr_pkg::CODE_SCAN_WDT, 1'b0, 1'b1, 1'b0},
    '{15'h0010, 6'h00, fcr_pkg::CODE_OPER_RUN, 1'b0, 1'b1, 1'b0},
    '{15'h0020, 6'h00, fcr_pkg::CODE_STACK,    1'b0, 1'b1, 1'b0},
    '{15'h0080, 6'h00, fcr_pkg::CODE_TMR_IDX,  1'b0, 1'b1, 1'b0},
    '{15'h0080, 6'h04, fcr_pkg::CODE_TMR_IDX,  1'b1, 1'b0, 1'b1},
    '{15'h0100, 6'h00, fcr_pkg::CODE_EXT_DEV,  1'b0, 1'b0, 1'b0},
    '{15'h0100, 6'h08, fcr_pkg::CODE_EXT_DEV,  1'b1, 1'b0, 1'b1},
    '{15'h0200, 6'h00, fcr_pkg::CODE_TASK_OVF, 1'b0, 1'b0, 1'b0},
    '{15'h0200, 6'h10, fcr_pkg::CODE_TASK_OVF, 1'b1, 1'b0, 1'b1},
    '{15'h0400, 6'h00, fcr_pkg::CODE_ESTOP,    1'b0, 1'b1, 1'b0},
    '{15'h0800, 6'h00, fcr_pkg::CODE_OPER_ERR, 1'b0, 1'b0, 1'b0},
    '{15'h0800, 6'h20, fcr_pkg::CODE_OPER_ERR, 1'b1, 1'b0, 1'b1}
  };

  fcr_base_model u_base (
    .clk_i       (clk_i),
    .scan_en_i   (scan_en),
    .brk_io_i    (flt[0]),
    .brk_spec_i  (flt[1]),
    .scan_end_o  (scan_end),
    .io_fail_o   (io_fail),
    .spec_fail_o (spec_fail)
  );

  fcr_top u_dut (
    .clk_i (clk_i), .rst_n_i (rst_n_i), .run_req_i (run_req), .restart_i (restart),
    .scan_end_i (scan_end), .prog_active_i (prog_act), .prog_reload_i (reload),
    .cont_io_i (cont_sel[0]), .cont_spec_i (cont_sel[1]), .cont_tmr_i (cont_sel[2]),
    .cont_ext_i (cont_sel[3]), .cont_task_i (cont_sel[4]), .cont_oper_i (cont_sel[5]),
    .io_fail_i (io_fail), .spec_fail_i (spec_fail), .cpu_halt_i (flt[2]),
    .scan_wdt_i (flt[3]), .oper_run_i (flt[4]), .stack_bad_i (flt[5]),
    .base_dup_i (flt[6]), .tmr_idx_i (flt[7]), .ext_fault_i (flt[8]),
    .task_ovf_i (flt[9]), .estop_i (flt[10]), .oper_err_i (flt[11]),
    .oper_step_i (16'h5a3c), .backup_lost_i (flt[12]), .rtc_bad_i (flt[13]),
    .cell_low_i (flt[14]), .hist_wr_i (hist_wr), .hist_code_i (hist_code),
    .hist_idx_i (hist_idx), .hist_code_o (hist_code_o), .hist_count_o (hist_count_o),
    .err_code_o (err_code_o), .err_step_o (err_step_o), .running_o (running_o),
    .run_led_o (run_led_o), .err_led_o (err_led_o), .cont_fault_led_o (cont_fault_led_o),
    .clock_warning_indicator_o (clock_warning_indicator_o),
    .cell_low_indicator_o (cell_low_indicator_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // Faults in rf are present when reset releases, for the reset diagnostic point.
  task automatic start_run(input logic [14:0] rf);
    rst_n_i = 1'b0;
    run_req = 1'b0;
    reload  = 1'b0;
    flt     = rf;
    cyc(4);
    rst_n_i = 1'b1;
    cyc(1);
    flt     = '0;
    run_req = 1'b1;
    cyc(2);
  endtask : start_run

  task automatic fault_then_restart(input logic [14:0] f);
    start_run('0);
    flt = f;
    cyc(3);
    flt = '0;
    cyc(1);
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(2);
  endtask : fault_then_restart

  task automatic hwr(input logic [9:0] c);
    hist_code = c;
    hist_wr   = 1'b1;
    cyc(1);
    hist_wr   = 1'b0;
    cyc(1);
  endtask : hwr

  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    #(40 * 5000);
    errors++;
    conclude();
  end

  initial begin
    errors = 0; tests_run = 0; rst_n_i = 1'b0; run_req = 1'b0; restart = 1'b0;
    prog_act = 1'b1; reload = 1'b0; scan_en = 1'b1; flt = '0; cont_sel = '0;
    hist_wr = 1'b0; hist_code = '0; hist_idx = '0;
    cyc(2);
    `EXPECT("reset code", 10'h000, err_code_o)
    `EXPECT("reset running", 1'b0, running_o)
    for (int i = 0; i < 17; i++) begin
      start_run('0);
      `EXPECT("running", 1'b1, running_o)
      cont_sel = rows[i].c;
      flt      = rows[i].f;
      cyc(6);
      flt      = '0;
      cyc(2);
      `EXPECT("code", rows[i].code, err_code_o)
      `EXPECT("state", rows[i].run, running_o)
      `EXPECT("err_led", 1'b1, err_led_o)
      `EXPECT("cont_led", rows[i].cled, cont_fault_led_o)
      if (!rows[i].cled) `EXPECT("run_led", rows[i].rled, run_led_o)
      if (rows[i].cled && rows[i].code == fcr_pkg::CODE_OPER_ERR)
        `EXPECT("step", 16'h5a3c, err_step_o)
    end
    cont_sel = '0;
    start_run('0);
    scan_en  = 1'b0;
    prog_act = 1'b0;
    flt      = 15'h0021;
    cyc(6);
    `EXPECT("no point code", 10'h000, err_code_o)
    `EXPECT("no point run", 1'b1, running_o)
    flt      = 15'h0005;
    scan_en  = 1'b1;
    prog_act = 1'b1;
    cyc(6);
    `EXPECT("priority", fcr_pkg::CODE_CPU_HALT, err_code_o)
    fault_then_restart(15'h0020);
    `EXPECT("restart code", 10'h000, err_code_o)
    `EXPECT("restart led", 1'b0, err_led_o)
    fault_then_restart(15'h0010);
    `EXPECT("no reload", fcr_pkg::CODE_OPER_RUN, err_code_o)
    reload  = 1'b1;
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(2);
    `EXPECT("reloaded", 10'h000, err_code_o)
    fault_then_restart(15'h0400);
    `EXPECT("lock", fcr_pkg::CODE_ESTOP, err_code_o)
    start_run(15'h1000);
    `EXPECT("backup code", fcr_pkg::CODE_BACKUP, err_code_o)
    `EXPECT("backup run", 1'b0, running_o)
    start_run(15'h0040);
    `EXPECT("base code", fcr_pkg::CODE_BASE_DUP, err_code_o)
    `EXPECT("base run_led", 1'b0, run_led_o)
    `EXPECT("base err_led", 1'b1, err_led_o)
    start_run('0);
    run_req = 1'b0;
    cyc(2);
    flt     = 15'h0040;
    run_req = 1'b1;
    cyc(2);
    `EXPECT("base switch code", fcr_pkg::CODE_BASE_DUP, err_code_o)
    `EXPECT("base switch run", 1'b0, running_o)
    start_run('0);
    flt = 15'h2000;
    cyc(2);
    `EXPECT("rtc lamp", 1'b1, clock_warning_indicator_o)
    `EXPECT("rtc code", 10'h000, err_code_o)
    `EXPECT("rtc run", 1'b1, running_o)
    flt = 15'h4000;
    cyc(2);
    `EXPECT("cell lamp", 1'b1, cell_low_indicator_o)
    `EXPECT("rtc off", 1'b0, clock_warning_indicator_o)
    `EXPECT("cell run", 1'b1, running_o)
    flt = '0;
    hwr(10'h016);
    hwr(10'h017);
    hwr(10'h001);
    hwr(10'h000);
    `EXPECT("hist count", 4'h2, hist_count_o)
    hist_idx = 3'h0;
    cyc(2);
    `EXPECT("hist 0", 10'h016, hist_code_o)
    hist_idx = 3'h1;
    cyc(2);
    `EXPECT("hist 1", 10'h001, hist_code_o)
    conclude();
  end
endmodule : fcr_top_tb
